/* File: design/bid_pkg.sv */
// Constants, types and helpers shared by the interrupt dispatcher
package bid_pkg;
	// Source lines, little-endian positions
	localparam int BID_SRC_N = 11;
	localparam int BID_IDX_W = 4;
	localparam int BID_BIT_INTA = 0;
	localparam int BID_BIT_INTF = 5;
	localparam int BID_BIT_HOST_EXT = 6;
	localparam int BID_BIT_BUS_ERR = 7;
	localparam int BID_BIT_KBD_MOUSE = 8;
	localparam int BID_BIT_UNUSED = 9;
	localparam int BID_BIT_SERIAL = 10;
	localparam logic [10:0] BID_IMPL_MASK = 11'h5FF;
	// Big-endian index of a bit is this minus its little-endian index
	localparam int BID_BE_TOP = 31;

	// Delivery target layout
	localparam int BID_TGT_ADDR_LSB = 5;
	localparam int BID_TGT_GRP_W = 5;
	localparam int BID_DATA_PAD_W = 27;

	// Register byte offsets
	localparam int BID_ADDR_W = 12;
	localparam logic [11:0] BID_OFF_TGT0 = 12'h004;
	localparam logic [11:0] BID_OFF_REQ0 = 12'h00C;
	localparam logic [11:0] BID_OFF_TGT1 = 12'h010;
	localparam logic [11:0] BID_OFF_REQ1 = 12'h014;
	localparam logic [11:0] BID_OFF_MASK = 12'h018;
	localparam logic [11:0] BID_OFF_PEND = 12'h01C;
	localparam logic [11:0] BID_OFF_ROUTE = 12'h024;
	localparam logic [11:0] BID_OFF_LEVEL = 12'h028;
	localparam logic [11:0] BID_OFF_EVSTAT = 12'h030;
	localparam logic [11:0] BID_OFF_EVMASK = 12'h034;
	localparam logic [11:0] BID_OFF_HBMASK = 12'h800;

	// Reset values
	localparam logic [31:0] BID_RST_TGT = 32'h00000000;
	localparam logic [10:0] BID_RST_SRC = 11'h000;
	localparam logic BID_RST_HBMASK = 1'b1;
	localparam logic [2:0] BID_RST_EV = 3'h0;

	// Event status bits
	localparam int BID_EV_N = 3;
	localparam int BID_EV_REQ0 = 0;
	localparam int BID_EV_REQ1 = 1;
	localparam int BID_EV_SENT = 2;

	localparam logic [1:0] BID_RESP_OKAY = 2'h0;
	localparam logic [1:0] BID_RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {BID_IDLE, BID_ARB, BID_XFER} bid_state_type;

	function automatic int bid_be_index(input int le);
		return BID_BE_TOP - le;
	endfunction

	function automatic logic [31:0] bid_merge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old_v;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return res;
	endfunction
endpackage

/* File: design/bid_dlv_if.sv */
// Link between the register core and the host-bus delivery engine
`timescale 1ns/1ps
interface bid_dlv_if;
	logic [10:0] new0;
	logic [10:0] new1;
	logic [31:0] tgt0;
	logic [31:0] tgt1;
	logic hb_mask;
	logic hb_gnt;
	logic hb_ack;
	logic hb_req;
	logic hb_valid;
	logic [31:0] hb_addr;
	logic [31:0] hb_data;
	logic sent;
	modport ctrl (output new0, new1, tgt0, tgt1, hb_mask, hb_gnt, hb_ack,
		input hb_req, hb_valid, hb_addr, hb_data, sent);
	modport eng (input new0, new1, tgt0, tgt1, hb_mask, hb_gnt, hb_ack,
		output hb_req, hb_valid, hb_addr, hb_data, sent);
endinterface

/* File: design/bid_engine.sv */
// Host-bus delivery engine: one interrupt write per newly set request bit
`timescale 1ns/1ps
module bid_engine (
	input wire logic aclk,
	input wire logic aresetn,
	bid_dlv_if.eng dl
);
	import bid_pkg::*;

	bid_state_type state_r, state_nxt;
	logic [10:0] owed0_r, owed0_nxt;
	logic [10:0] owed1_r, owed1_nxt;
	logic sel_r, sel_nxt;
	logic [BID_IDX_W-1:0] bit_r, bit_nxt;
	logic req_r, req_nxt;
	logic valid_r, valid_nxt;
	logic [31:0] addr_r, addr_nxt;
	logic [31:0] data_r, data_nxt;
	logic sent_r, sent_nxt;
	logic [31:0] tgt;

	function automatic logic [BID_IDX_W-1:0] lowest(input logic [10:0] v);
		logic [BID_IDX_W-1:0] r;
		r = '0;
		for (int i = BID_SRC_N - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = BID_IDX_W'(i);
			end
		end
		return r;
	endfunction

	always_comb begin
		state_nxt = state_r;
		sel_nxt = sel_r;
		bit_nxt = bit_r;
		req_nxt = req_r;
		valid_nxt = valid_r;
		addr_nxt = addr_r;
		data_nxt = data_r;
		sent_nxt = 1'b0;
		// Fresh request bits always land, even on the clearing edge
		owed0_nxt = owed0_r | dl.new0;
		owed1_nxt = owed1_r | dl.new1;
		tgt = sel_r ? dl.tgt1 : dl.tgt0;
		case (state_r)
			BID_IDLE: begin
				if (!dl.hb_mask && (|owed0_r || |owed1_r)) begin
					req_nxt = 1'b1;
					sel_nxt = ~(|owed0_r);
					bit_nxt = lowest(|owed0_r ? owed0_r : owed1_r);
					state_nxt = BID_ARB;
				end
			end
			BID_ARB: begin
				if (dl.hb_mask) begin
					req_nxt = 1'b0;
					state_nxt = BID_IDLE;
				end else if (dl.hb_gnt) begin
					valid_nxt = 1'b1;
					addr_nxt = {tgt[31:BID_TGT_ADDR_LSB], BID_TGT_ADDR_LSB'(0)};
					data_nxt = {BID_DATA_PAD_W'(0), tgt[BID_TGT_GRP_W-1:0]};
					state_nxt = BID_XFER;
				end
			end
			BID_XFER: begin
				// A granted write completes even if the mask rises meanwhile
				if (dl.hb_ack) begin
					valid_nxt = 1'b0;
					req_nxt = 1'b0;
					sent_nxt = 1'b1;
					if (sel_r) begin
						owed1_nxt[bit_r] = dl.new1[bit_r];
					end else begin
						owed0_nxt[bit_r] = dl.new0[bit_r];
					end
					state_nxt = BID_IDLE;
				end
			end
			default: begin
				req_nxt = 1'b0;
				valid_nxt = 1'b0;
				state_nxt = BID_IDLE;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r <= BID_IDLE;
			owed0_r <= BID_RST_SRC;
			owed1_r <= BID_RST_SRC;
			sel_r <= 1'b0;
			bit_r <= '0;
			req_r <= 1'b0;
			valid_r <= 1'b0;
			addr_r <= '0;
			data_r <= '0;
			sent_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			owed0_r <= owed0_nxt;
			owed1_r <= owed1_nxt;
			sel_r <= sel_nxt;
			bit_r <= bit_nxt;
			req_r <= req_nxt;
			valid_r <= valid_nxt;
			addr_r <= addr_nxt;
			data_r <= data_nxt;
			sent_r <= sent_nxt;
		end
	end

	assign dl.hb_req = req_r;
	assign dl.hb_valid = valid_r;
	assign dl.hb_addr = addr_r;
	assign dl.hb_data = data_r;
	assign dl.sent = sent_r;
endmodule

/* File: design/bid_top.sv */
// Bridge interrupt dispatcher: register file, source capture and delivery
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ps
module bid_top #(
	parameter int ADDR_W = bid_pkg::BID_ADDR_W
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [bid_pkg::BID_SRC_N-1:0] irq_in,
	output logic hb_req,
	input wire logic hb_gnt,
	output logic hb_valid,
	output logic [31:0] hb_addr,
	output logic [31:0] hb_data,
	input wire logic hb_ack,
	output logic irq_out
);
	import bid_pkg::*;

	if (ADDR_W < BID_ADDR_W || ADDR_W > 32) begin : g_chk
		$error("bid_top: ADDR_W must lie between 12 and 32");
	end

	// AXI write side and writable registers
	logic aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt;
	logic [11:0] waddr_r, waddr_nxt;
	logic [31:0] wdata_r, wdata_nxt;
	logic [3:0] wstrb_r, wstrb_nxt;
	logic awready_r, awready_nxt, wready_r, wready_nxt;
	logic bvalid_r, bvalid_nxt;
	logic [1:0] bresp_r, bresp_nxt;
	logic [31:0] tgt0_r, tgt0_nxt, tgt1_r, tgt1_nxt;
	logic [10:0] en_mask_r, en_mask_nxt, route_sel_r, route_sel_nxt;
	logic hb_mask_r, hb_mask_nxt;
	logic [2:0] ien_r, ien_nxt;
	logic pend_wr, wr_go;
	logic [2:0] ev_w1c;
	logic [31:0] merged;

	// AXI read side
	logic arready_r, arready_nxt, rvalid_r, rvalid_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic [1:0] rresp_r, rresp_nxt;
	logic rd_clr0_r, rd_clr0_nxt, rd_clr1_r, rd_clr1_nxt;
	logic [11:0] raddr;

	// Source capture and request state
	logic [10:0] s1_r, s2_r, s3_r;
	logic [10:0] lvl_r, lvl_nxt, pend_r, pend_nxt;
	logic [10:0] req0_r, req0_nxt, req1_r, req1_nxt;
	logic [10:0] rise, clr0, clr1, route0, route1;

	// Event status and interrupt output
	logic [2:0] ev_r, ev_nxt;
	logic [2:0] ev_set;
	logic irq_r, irq_nxt;

	bid_dlv_if dl ();

	always_comb begin
		aw_hold_nxt = aw_hold_r;
		w_hold_nxt = w_hold_r;
		waddr_nxt = waddr_r;
		wdata_nxt = wdata_r;
		wstrb_nxt = wstrb_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt = bresp_r;
		tgt0_nxt = tgt0_r;
		tgt1_nxt = tgt1_r;
		en_mask_nxt = en_mask_r;
		route_sel_nxt = route_sel_r;
		hb_mask_nxt = hb_mask_r;
		ien_nxt = ien_r;
		pend_wr = 1'b0;
		ev_w1c = '0;
		merged = '0;
		// Address and data may arrive in either order
		if (s_axi_awvalid && awready_r) begin
			aw_hold_nxt = 1'b1;
			waddr_nxt = {s_axi_awaddr[11:2], 2'h0};
		end
		if (s_axi_wvalid && wready_r) begin
			w_hold_nxt = 1'b1;
			wdata_nxt = s_axi_wdata;
			wstrb_nxt = s_axi_wstrb;
		end
		if (s_axi_bvalid && s_axi_bready) begin
			bvalid_nxt = 1'b0;
		end
		wr_go = aw_hold_r && w_hold_r && !bvalid_r;
		if (wr_go) begin
			aw_hold_nxt = 1'b0;
			w_hold_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt = BID_RESP_OKAY;
			case (waddr_r)
				BID_OFF_TGT0: tgt0_nxt = bid_merge(tgt0_r, wdata_r, wstrb_r);
				BID_OFF_TGT1: tgt1_nxt = bid_merge(tgt1_r, wdata_r, wstrb_r);
				BID_OFF_MASK: begin
					merged = bid_merge({21'h0, en_mask_r}, wdata_r, wstrb_r);
					en_mask_nxt = merged[10:0] & BID_IMPL_MASK;
				end
				BID_OFF_ROUTE: begin
					merged = bid_merge({21'h0, route_sel_r}, wdata_r, wstrb_r);
					route_sel_nxt = merged[10:0] & BID_IMPL_MASK;
				end
				BID_OFF_PEND: pend_wr = 1'b1;
				BID_OFF_HBMASK: hb_mask_nxt = wstrb_r[0] ? wdata_r[0] : hb_mask_r;
				BID_OFF_EVSTAT: ev_w1c = wstrb_r[0] ? wdata_r[2:0] : 3'h0;
				BID_OFF_EVMASK: ien_nxt = wstrb_r[0] ? wdata_r[2:0] : ien_r;
				// Read-only registers accept writes without effect
				BID_OFF_REQ0, BID_OFF_REQ1, BID_OFF_LEVEL: bresp_nxt = BID_RESP_OKAY;
				default: bresp_nxt = BID_RESP_SLVERR;
			endcase
		end
		awready_nxt = !aw_hold_nxt && !bvalid_nxt;
		wready_nxt = !w_hold_nxt && !bvalid_nxt;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_r <= 1'b0;
			w_hold_r <= 1'b0;
			waddr_r <= '0;
			wdata_r <= '0;
			wstrb_r <= '0;
			awready_r <= 1'b0;
			wready_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= BID_RESP_OKAY;
			tgt0_r <= BID_RST_TGT;
			tgt1_r <= BID_RST_TGT;
			en_mask_r <= BID_RST_SRC;
			route_sel_r <= BID_RST_SRC;
			hb_mask_r <= BID_RST_HBMASK;
			ien_r <= BID_RST_EV;
		end else begin
			aw_hold_r <= aw_hold_nxt;
			w_hold_r <= w_hold_nxt;
			waddr_r <= waddr_nxt;
			wdata_r <= wdata_nxt;
			wstrb_r <= wstrb_nxt;
			awready_r <= awready_nxt;
			wready_r <= wready_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			tgt0_r <= tgt0_nxt;
			tgt1_r <= tgt1_nxt;
			en_mask_r <= en_mask_nxt;
			route_sel_r <= route_sel_nxt;
			hb_mask_r <= hb_mask_nxt;
			ien_r <= ien_nxt;
		end
	end

	always_comb begin
		arready_nxt = arready_r;
		rvalid_nxt = rvalid_r;
		rdata_nxt = rdata_r;
		rresp_nxt = rresp_r;
		rd_clr0_nxt = 1'b0;
		rd_clr1_nxt = 1'b0;
		raddr = {s_axi_araddr[11:2], 2'h0};
		if (s_axi_rvalid && s_axi_rready) begin
			rvalid_nxt = 1'b0;
		end
		if (s_axi_arvalid && arready_r) begin
			rvalid_nxt = 1'b1;
			rresp_nxt = BID_RESP_OKAY;
			rdata_nxt = '0;
			case (raddr)
				BID_OFF_TGT0: rdata_nxt = tgt0_r;
				BID_OFF_TGT1: rdata_nxt = tgt1_r;
				BID_OFF_REQ0: begin
					rdata_nxt = {21'h0, req0_r};
					rd_clr0_nxt = 1'b1;
				end
				BID_OFF_REQ1: begin
					rdata_nxt = {21'h0, req1_r};
					rd_clr1_nxt = 1'b1;
				end
				BID_OFF_MASK: rdata_nxt = {21'h0, en_mask_r};
				BID_OFF_ROUTE: rdata_nxt = {21'h0, route_sel_r};
				BID_OFF_PEND: rdata_nxt = {21'h0, pend_r};
				BID_OFF_LEVEL: rdata_nxt = {21'h0, lvl_r};
				BID_OFF_HBMASK: rdata_nxt = {31'h0, hb_mask_r};
				BID_OFF_EVSTAT: rdata_nxt = {29'h0, ev_r};
				BID_OFF_EVMASK: rdata_nxt = {29'h0, ien_r};
				default: rresp_nxt = BID_RESP_SLVERR;
			endcase
		end
		arready_nxt = !rvalid_nxt;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_r <= 1'b0;
			rvalid_r <= 1'b0;
			rdata_r <= '0;
			rresp_r <= BID_RESP_OKAY;
			rd_clr0_r <= 1'b0;
			rd_clr1_r <= 1'b0;
		end else begin
			arready_r <= arready_nxt;
			rvalid_r <= rvalid_nxt;
			rdata_r <= rdata_nxt;
			rresp_r <= rresp_nxt;
			rd_clr0_r <= rd_clr0_nxt;
			rd_clr1_r <= rd_clr1_nxt;
		end
	end

	always_comb begin
		// Level only moves once the two later stages agree
		lvl_nxt = lvl_r;
		rise = '0;
		if (s2_r == s3_r) begin
			lvl_nxt = s3_r & BID_IMPL_MASK;
			rise = s3_r & ~lvl_r & BID_IMPL_MASK;
		end
		clr0 = rd_clr0_r ? req0_r : '0;
		clr1 = rd_clr1_r ? req1_r : '0;
		route0 = en_mask_r & ~route_sel_r;
		route1 = en_mask_r & route_sel_r;
		// A rising edge wins over any clear on the same edge
		if (pend_wr) begin
			pend_nxt = rise;
		end else begin
			pend_nxt = (pend_r & ~clr0 & ~clr1) | rise;
		end
		req0_nxt = ((req0_r | (pend_r & route0)) & ~clr0) | (rise & route0);
		req1_nxt = ((req1_r | (pend_r & route1)) & ~clr1) | (rise & route1);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_r <= BID_RST_SRC;
			s2_r <= BID_RST_SRC;
			s3_r <= BID_RST_SRC;
			lvl_r <= BID_RST_SRC;
			pend_r <= BID_RST_SRC;
			req0_r <= BID_RST_SRC;
			req1_r <= BID_RST_SRC;
		end else begin
			s1_r <= irq_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
			lvl_r <= lvl_nxt;
			pend_r <= pend_nxt;
			req0_r <= req0_nxt;
			req1_r <= req1_nxt;
		end
	end

	always_comb begin
		ev_set = '0;
		ev_set[BID_EV_REQ0] = |dl.new0;
		ev_set[BID_EV_REQ1] = |dl.new1;
		ev_set[BID_EV_SENT] = dl.sent;
		ev_nxt = (ev_r & ~ev_w1c) | ev_set;
		irq_nxt = |(ev_nxt & ien_nxt);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ev_r <= BID_RST_EV;
			irq_r <= 1'b0;
		end else begin
			ev_r <= ev_nxt;
			irq_r <= irq_nxt;
		end
	end

	assign dl.new0 = req0_nxt & ~req0_r;
	assign dl.new1 = req1_nxt & ~req1_r;
	assign dl.tgt0 = tgt0_r;
	assign dl.tgt1 = tgt1_r;
	assign dl.hb_mask = hb_mask_r;
	assign dl.hb_gnt = hb_gnt;
	assign dl.hb_ack = hb_ack;

	bid_engine u_engine (
		.aclk(aclk),
		.aresetn(aresetn),
		.dl(dl.eng)
	);

	assign s_axi_awready = awready_r;
	assign s_axi_wready = wready_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;
	assign hb_req = dl.hb_req;
	assign hb_valid = dl.hb_valid;
	assign hb_addr = dl.hb_addr;
	assign hb_data = dl.hb_data;
	assign irq_out = irq_r;
endmodule

/* File: tb/bid_checker.sv */
// Port assertions for the interrupt dispatcher
`timescale 1ns/1ps
module bid_checker (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic hb_req,
	input wire logic hb_gnt,
	input wire logic hb_valid,
	input wire logic [31:0] hb_addr,
	input wire logic [31:0] hb_data,
	input wire logic hb_ack
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_grant;
		hb_req && hb_gnt && !hb_valid;
	endsequence
	sequence s_done;
		hb_valid && hb_ack;
	endsequence
	a_addr_low_zero: assert property (hb_valid |-> hb_addr[4:0] == 5'h00)
		else $error("write address low bits set");
	a_data_pad_zero: assert property (hb_valid |-> hb_data[31:5] == 27'h0)
		else $error("write data upper bits set");
	a_valid_after_grant: assert property ($rose(hb_valid) |-> $past(hb_req && hb_gnt))
		else $error("write started without grant");
	a_grant_to_valid: assert property (s_grant |=> hb_valid)
		else $error("grant not followed by write");
	a_write_holds: assert property (hb_valid && !hb_ack |=>
		hb_valid && hb_req && $stable(hb_addr) && $stable(hb_data))
		else $error("write changed before ack");
	a_ack_ends: assert property (s_done |=> !hb_valid && !hb_req)
		else $error("write not ended after ack");
	a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
endmodule
bind bid_top bid_checker u_chk (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
	.hb_req, .hb_gnt, .hb_valid, .hb_addr, .hb_data, .hb_ack);

/* File: tb/bid_host_model.sv */
// Host-bus arbiter and external interrupt register model
`timescale 1ns/1ps
module bid_host_model (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [3:0] delay,
	input wire logic hb_req,
	input wire logic hb_valid,
	input wire logic [31:0] hb_addr,
	input wire logic [31:0] hb_data,
	output logic hb_gnt,
	output logic hb_ack
);
	logic [4:0] wait_r;
	int writes;
	logic [31:0] last_addr;
	logic [31:0] last_data;
	always @(posedge aclk) begin
		if (!aresetn) begin
			hb_gnt <= 1'b0;
			hb_ack <= 1'b0;
			wait_r <= 5'h00;
			writes <= 0;
		end else begin
			wait_r <= ((hb_req || hb_valid) && !hb_ack) ? wait_r + 5'h01 : 5'h00;
			// Grant only a live request, after the arbitration delay
			hb_gnt <= hb_req && !hb_valid && wait_r >= {1'b0, delay};
			hb_ack <= hb_valid && !hb_ack && wait_r >= {delay, 1'b0};
			if (hb_valid && hb_ack) begin
				writes <= writes + 1;
				last_addr <= hb_addr;
				last_data <= hb_data;
			end
		end
	end
endmodule

/* File: tb/test_bridge_interrupt_dispatcher.sv */
// Self-checking bench for the interrupt dispatcher
`timescale 1ns/1ps
module test_bridge_interrupt_dispatcher;
	import bid_pkg::*;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic hb_req, hb_gnt, hb_valid, hb_ack, irq_out;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, hb_addr, hb_data, d;
	logic [3:0] s_axi_wstrb, delay;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic [10:0] irq_in;
	int bad_count, checked, cycles, req_cnt;
	bid_top #(.ADDR_W(12)) dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq_in, .hb_req, .hb_gnt, .hb_valid,
		.hb_addr, .hb_data, .hb_ack, .irq_out);
	bid_host_model host (.aclk, .aresetn, .delay, .hb_req, .hb_valid, .hb_addr, .hb_data,
		.hb_gnt, .hb_ack);
	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end
	always @(negedge aclk) begin
		if (hb_req) req_cnt++;
	end
	always @(posedge aclk) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			close_out();
		end
	end
	task automatic close_out();
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t: %s got %h want %h", $time, m, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge aclk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [1:0] e);
		logic aw, w;
		aw = 1'b0;
		w = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= v;
		s_axi_wvalid <= 1'b1;
		while (!(aw && w)) begin
			@(negedge aclk);
			aw = aw || s_axi_awready;
			w = w || s_axi_wready;
			@(posedge aclk);
			if (aw) s_axi_awvalid <= 1'b0;
			if (w) s_axi_wvalid <= 1'b0;
		end
		do @(negedge aclk); while (!s_axi_bvalid);
		chk({30'h0, s_axi_bresp}, {30'h0, e}, "bresp");
		// Late ready keeps the response standing for a cycle
		@(posedge aclk);
		s_axi_bready <= 1'b1;
		@(posedge aclk);
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] e);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(negedge aclk); while (!s_axi_arready);
		@(posedge aclk);
		s_axi_arvalid <= 1'b0;
		do @(negedge aclk); while (!s_axi_rvalid);
		// Late ready keeps the data standing for a cycle
		@(posedge aclk);
		s_axi_rready <= 1'b1;
		@(negedge aclk);
		v = s_axi_rdata;
		e = s_axi_rresp;
		@(posedge aclk);
		s_axi_rready <= 1'b0;
	endtask
	task automatic rc(input logic [11:0] a, input logic [31:0] x, input string m);
		rd(a, d, r);
		chk(d, x, m);
		chk({30'h0, r}, {30'h0, BID_RESP_OKAY}, m);
	endtask
	task automatic wait_wr(input int n);
		for (int i = 0; i < 300 && host.writes < n; i++) @(negedge aclk);
		chk(host.writes, n, "write count");
		@(posedge aclk);
	endtask
	task automatic t_reset();
		rc(BID_OFF_HBMASK, 32'h1, "bus mask reset");
		rc(BID_OFF_MASK, 32'h0, "mask reset");
		rc(BID_OFF_ROUTE, 32'h0, "route reset");
		rc(BID_OFF_TGT1, 32'h0, "target reset");
		rd(12'h100, d, r);
		chk({30'h0, r}, {30'h0, BID_RESP_SLVERR}, "unmapped read");
		chk(d, 32'h0, "unmapped data");
		wr(12'h100, 32'hFFFFFFFF, BID_RESP_SLVERR);
		wr(BID_OFF_REQ0, 32'hFFFFFFFF, BID_RESP_OKAY);
		rc(BID_OFF_REQ0, 32'h0, "request read only");
		$display("t_reset done");
	endtask
	task automatic t_deliver();
		wr(BID_OFF_TGT0, 32'hABCDE0F3, BID_RESP_OKAY);
		wr(BID_OFF_TGT1, 32'h1234567C, BID_RESP_OKAY);
		rc(BID_OFF_TGT0, 32'hABCDE0F3, "target 0");
		wr(BID_OFF_ROUTE, 32'h400, BID_RESP_OKAY);
		wr(BID_OFF_MASK, 32'hFFFFFFFF, BID_RESP_OKAY);
		rc(BID_OFF_MASK, 32'h5FF, "mask bits");
		wr(BID_OFF_HBMASK, 32'h0, BID_RESP_OKAY);
		irq_in <= 11'h001;
		wait_wr(1);
		chk(host.last_addr, 32'hABCDE0E0, "addr 0");
		chk(host.last_data, 32'h13, "data 0");
		irq_in <= 11'h401;
		wait_wr(2);
		chk(host.last_addr, 32'h12345660, "addr 1");
		chk(host.last_data, 32'h1C, "data 1");
		rc(BID_OFF_REQ0, 32'h001, "request 0");
		rc(BID_OFF_PEND, 32'h400, "pending partly cleared");
		rc(BID_OFF_REQ0, 32'h0, "request 0 cleared");
		rc(BID_OFF_REQ1, 32'h400, "request 1");
		rc(BID_OFF_PEND, 32'h0, "pending cleared");
		rc(BID_OFF_LEVEL, 32'h401, "level");
		$display("t_deliver done");
	endtask
	task automatic t_edge();
		tick(12);
		rc(BID_OFF_PEND, 32'h0, "held line");
		wr(BID_OFF_MASK, 32'h07F, BID_RESP_OKAY);
		irq_in <= 11'h681;
		tick(8);
		rc(BID_OFF_LEVEL, 32'h481, "level unused bit");
		rc(BID_OFF_PEND, 32'h080, "pending disabled");
		rc(BID_OFF_REQ0, 32'h0, "disabled request");
		wr(BID_OFF_PEND, 32'h0, BID_RESP_OKAY);
		rc(BID_OFF_PEND, 32'h0, "pending write");
		chk(host.writes, 2, "no extra write");
		$display("t_edge done");
	endtask
	task automatic t_host_bus_request_mask();
		int s;
		delay <= 4'h5;
		wr(BID_OFF_HBMASK, 32'h1, BID_RESP_OKAY);
		s = req_cnt;
		irq_in <= 11'h002;
		tick(40);
		chk(req_cnt, s, "request while masked");
		chk(host.writes, 2, "write while masked");
		wr(BID_OFF_HBMASK, 32'h0, BID_RESP_OKAY);
		wait_wr(3);
		chk(host.last_addr, 32'hABCDE0E0, "late addr");
		rc(BID_OFF_REQ0, 32'h002, "request bit 1");
		$display("t_host_bus_request_mask done");
	endtask
	task automatic t_irq();
		rc(BID_OFF_EVSTAT, 32'h7, "events");
		@(negedge aclk);
		chk({31'h0, irq_out}, 32'h0, "irq masked");
		wr(BID_OFF_EVMASK, 32'h4, BID_RESP_OKAY);
		tick(2);
		@(negedge aclk);
		chk({31'h0, irq_out}, 32'h1, "irq raised");
		wr(BID_OFF_EVSTAT, 32'h4, BID_RESP_OKAY);
		tick(2);
		@(negedge aclk);
		chk({31'h0, irq_out}, 32'h0, "irq cleared");
		rc(BID_OFF_EVSTAT, 32'h3, "one to clear");
		$display("t_irq done");
	endtask
	initial begin
		aresetn = 1'b0;
		s_axi_awaddr = 12'h000;
		s_axi_awvalid = 1'b0;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hF;
		s_axi_wvalid = 1'b0;
		s_axi_bready = 1'b0;
		s_axi_araddr = 12'h000;
		s_axi_arvalid = 1'b0;
		s_axi_rready = 1'b0;
		irq_in = 11'h000;
		delay = 4'h1;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		tick(2);
		t_reset();
		t_deliver();
		t_edge();
		t_host_bus_request_mask();
		t_irq();
		close_out();
	end
endmodule
